// ---- spi_mm_regs.svh ----
`ifndef SPI_MM_REGS_SVH
`define SPI_MM_REGS_SVH

// ============================================================
// Widths and counts
`define SPI_DATA_W       8
`define SPI_RATE_W       3
`define SPI_HALF_CNT_W   11
`define SPI_EDGE_LAST    4'hF
`define SPI_BITS_LAST    3'h7
`define SPI_BUF_DEPTH    2

// ============================================================
// Reset values
`define SPI_MASTER_RST   1'h0
`define SPI_FLAG_RST     1'h0

`endif

// ---- spi_mm_pkg.sv ----
`include "spi_mm_regs.svh"

package spi_mm_pkg;

	// ============================================================
	// Configuration bits as one carrier
	typedef struct packed {
		logic                      cpol;
		logic                      cpha;
		logic                      select_output_enable;
		logic                      low_bit_first;
		logic                      fault_detect_enable;
		logic                      serial_pin_control;
		logic                      bidir_output_enable;
		logic [`SPI_RATE_W-1:0]    rate_preselect_bits;
		logic [`SPI_RATE_W-1:0]    rate_select_bits;
	} spi_cfg_t;

	typedef logic [`SPI_DATA_W-1:0] spi_byte_t;

	// ============================================================
	// Master sequencer, Gray along idle-lead-shift-done
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_LEAD  = 2'h1,
		ST_SHIFT = 2'h3,
		ST_DONE  = 2'h2
	} spi_state_t;

endpackage

// ---- spi_buf2.sv ----
`timescale 1ns/1ps
`default_nettype none

module spi_buf2
	import spi_mm_pkg::*;
(
	input  wire logic      clk_i,     // system clock
	input  wire logic      rst_i,     // sync reset, high
	input  wire spi_byte_t in_data_i, // word in
	input  wire logic      in_valid_i,// word offered
	output logic           in_ready_o,// room for a word
	output spi_byte_t      out_data_o,// head word, registered
	output logic           out_valid_o,// head valid
	input  wire logic      out_ready_i // consumer takes head
);

	// ============================================================
	// Two-slot storage, head always in slot 0
	spi_byte_t slot_r [`SPI_BUF_DEPTH];
	logic [1:0] count_r;
	logic       push;
	logic       pop;

	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign in_ready_o  = (count_r != 2'h2);
	assign out_valid_o = (count_r != 2'h0);
	assign out_data_o  = slot_r[0];

	// Occupancy; simultaneous push and pop keeps the count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= 2'h0;
		end else if (push && !pop) begin
			count_r <= count_r + 2'h1;
		end else if (pop && !push) begin
			count_r <= count_r - 2'h1;
		end
	end

	// Data moves toward the head on pop
	always_ff @(posedge clk_i) begin
		if (pop) begin
			slot_r[0] <= (count_r == 2'h2) ? slot_r[1] : in_data_i;
		end else if (push && count_r == 2'h0) begin
			slot_r[0] <= in_data_i;
		end
		if (push && (count_r == 2'h2 || (count_r == 2'h1 && !pop))) begin
			slot_r[1] <= in_data_i;
		end
	end

endmodule

`default_nettype wire

// ---- spi_master_mode_control.sv ----
`timescale 1ns/1ps
`default_nettype none

module spi_master_mode_control
	import spi_mm_pkg::*;
(
	input  wire logic      sys_clk_i,          // 25 MHz system clock
	input  wire logic      sys_rst_i,          // sync reset, high
	input  wire logic      enable_i,           // block enable
	input  wire spi_cfg_t  cfg_i,              // configuration bits
	input  wire logic      master_select_wr_i, // pulse: write master_select
	input  wire logic      master_select_val_i,// value written
	output logic           master_select_o,    // current master_select
	input  wire logic      stop_in_wait_i,     // halt clock in wait
	input  wire logic      wait_mode_i,        // cpu in wait
	input  wire logic      stop_mode_i,        // cpu in stop
	input  wire logic      serial_irq_enable_i,// irq enable
	input  wire logic      fault_clear_i,      // pulse: clear fault flag
	output logic           mode_fault_flag_o,  // sticky fault flag
	output logic           irq_o,              // interrupt request
	output logic           busy_o,             // transfer running
	input  wire spi_byte_t tx_data_i,          // data register write
	input  wire logic      tx_valid_i,         // write strobe
	output logic           tx_ready_o,         // holding register empty
	output spi_byte_t      rx_data_o,          // received byte
	output logic           rx_valid_o,         // received byte valid
	input  wire logic      rx_ready_i,         // consumer takes byte
	input  wire logic      sck_i,              // sck pin level
	output logic           sck_o,              // sck drive
	output logic           sck_oe_o,           // sck driven
	input  wire logic      mosi_i,             // mosi pin level
	output logic           mosi_o,             // mosi drive
	output logic           mosi_oe_o,          // mosi driven
	input  wire logic      miso_i,             // miso pin level
	output logic           miso_o,             // miso drive
	output logic           miso_oe_o,          // miso driven
	input  wire logic      ss_n_i,             // select pin level
	output logic           ss_n_o,             // select drive
	output logic           ss_oe_o             // select driven
);

	// ============================================================
	// Declarations
	spi_state_t                 state_r;
	spi_cfg_t                   cfg_prev_r;
	logic [`SPI_HALF_CNT_W-1:0] div_r;
	logic [`SPI_HALF_CNT_W-1:0] half_len;
	logic [3:0]                 edge_r;
	logic                       sck_r;
	spi_byte_t                  shreg_r;
	logic                       in_bit_r;
	spi_byte_t                  hold_r;
	logic                       hold_full_r;
	logic                       master_r;
	logic                       flag_r;
	logic                       clk_halt;
	logic                       tick;
	logic                       fault;
	logic                       cfg_abort;
	logic                       abort;
	logic                       start;
	logic                       master_in;
	logic                       out_bit;
	logic                       is_sample;
	logic                       is_shift;
	logic                       sck_prev_r;
	logic [2:0]                 sl_cnt_r;
	logic                       sl_active;
	logic                       sl_edge;
	logic                       sl_sample;
	logic                       sl_done;
	logic                       slave_in;
	spi_byte_t                  rx_push_data;
	logic                       rx_push;
	logic                       rx_room;
	logic                       mst_done;
	logic                       sl_done_q;

	// ============================================================
	// Mode, fault and abort conditions
	// Clock generation stops only in stop, or wait with stop_in_wait
	assign clk_halt  = stop_mode_i || (wait_mode_i && stop_in_wait_i);
	assign fault     = enable_i && master_r && cfg_i.fault_detect_enable
	                   && !cfg_i.select_output_enable && !ss_n_i;
	// Bidir enable only counts while single-wire mode is selected
	assign cfg_abort = master_r && state_r != ST_IDLE &&
	                   ({cfg_i.cpol, cfg_i.cpha, cfg_i.select_output_enable,
	                     cfg_i.low_bit_first, cfg_i.fault_detect_enable,
	                     cfg_i.serial_pin_control, cfg_i.rate_preselect_bits,
	                     cfg_i.rate_select_bits} !=
	                    {cfg_prev_r.cpol, cfg_prev_r.cpha,
	                     cfg_prev_r.select_output_enable, cfg_prev_r.low_bit_first,
	                     cfg_prev_r.fault_detect_enable, cfg_prev_r.serial_pin_control,
	                     cfg_prev_r.rate_preselect_bits, cfg_prev_r.rate_select_bits} ||
	                    (cfg_i.serial_pin_control &&
	                     cfg_i.bidir_output_enable != cfg_prev_r.bidir_output_enable));
	assign abort     = fault || cfg_abort || !enable_i;
	assign start     = enable_i && master_r && hold_full_r && state_r == ST_IDLE
	                   && !fault;

	// Configuration snapshot for change detection
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cfg_prev_r <= '0;
		end else begin
			cfg_prev_r <= cfg_i;
		end
	end

	// ============================================================
	// Baud rate generator: half period = (pre+1) * 2^sel cycles
	assign half_len = `SPI_HALF_CNT_W'(({8'h00, cfg_i.rate_preselect_bits} + 11'h001)
	                  << cfg_i.rate_select_bits);
	assign tick     = !clk_halt && (div_r == half_len - 11'h001);

	// Counter frozen while halted so a paused bit keeps its timing
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || state_r == ST_IDLE || abort) begin
			div_r <= '0;
		end else if (!clk_halt) begin
			div_r <= tick ? '0 : div_r + 11'h001;
		end
	end

	// ============================================================
	// master_select and fault flag
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			master_r <= `SPI_MASTER_RST;
		end else if (fault) begin
			master_r <= 1'h0;
		end else if (master_select_wr_i) begin
			master_r <= master_select_val_i;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			flag_r <= `SPI_FLAG_RST;
		end else if (fault) begin
			flag_r <= 1'h1;
		end else if (fault_clear_i) begin
			flag_r <= 1'h0;
		end
	end

	// ============================================================
	// Master sequencer
	assign is_sample = (edge_r[0] == cfg_i.cpha);
	assign is_shift  = !is_sample && !(cfg_i.cpha && edge_r == 4'h0);
	assign mst_done  = state_r == ST_DONE && rx_room;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || abort) begin
			state_r <= ST_IDLE;
			edge_r  <= 4'h0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start) begin
						state_r <= ST_LEAD;
					end
				end
				// Half SCK period here, then another half period in shift before the first clock edge
				ST_LEAD: begin
					if (tick) begin
						state_r <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (tick) begin
						edge_r <= edge_r + 4'h1;
						if (edge_r == `SPI_EDGE_LAST) begin
							state_r <= ST_DONE;
						end
					end
				end
				// Waits for room in the receive buffer
				ST_DONE: begin
					if (rx_room) begin
						state_r <= ST_IDLE;
						edge_r  <= 4'h0;
					end
				end
			endcase
		end
	end

	// SCK level; an abort puts it back at its idle polarity
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || state_r != ST_SHIFT || abort) begin
			sck_r <= cfg_i.cpol;
		end else if (tick) begin
			sck_r <= !sck_r;
		end
	end

	// ============================================================
	// Slave path, clocked by sampled sck while selected
	assign sl_active = enable_i && !master_r && !ss_n_i;
	assign sl_edge   = sl_active && (sck_i != sck_prev_r);
	assign sl_sample = sl_edge && ((sck_i != cfg_i.cpol) != cfg_i.cpha);
	assign sl_done   = sl_sample && sl_cnt_r == `SPI_BITS_LAST;

	// Slave ignores power modes to stay in step with its master
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sck_prev_r <= 1'h0;
			sl_cnt_r   <= 3'h0;
		end else begin
			sck_prev_r <= sck_i;
			if (!sl_active) begin
				sl_cnt_r <= 3'h0;
			end else if (sl_sample) begin
				sl_cnt_r <= sl_cnt_r + 3'h1;
			end
		end
	end

	// ============================================================
	// Shift register, shared by both roles
	assign master_in = cfg_i.serial_pin_control ? mosi_i : miso_i;
	assign slave_in  = cfg_i.serial_pin_control ? miso_i : mosi_i;
	assign out_bit   = cfg_i.low_bit_first ? shreg_r[0] : shreg_r[`SPI_DATA_W-1];

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			shreg_r  <= '0;
			in_bit_r <= 1'h0;
		end else if (start || (!master_r && ss_n_i && hold_full_r)) begin
			shreg_r <= hold_r;
		end else if (state_r == ST_SHIFT && tick) begin
			if (is_sample) begin
				in_bit_r <= master_in;
			end
			if (is_shift) begin
				shreg_r <= cfg_i.low_bit_first ? {in_bit_r, shreg_r[7:1]}
				                               : {shreg_r[6:0], in_bit_r};
			end
		end else if (state_r == ST_SHIFT && edge_r == 4'h0 && !tick) begin
			in_bit_r <= in_bit_r;
		end else if (sl_sample) begin
			in_bit_r <= slave_in;
			if (!cfg_i.cpha || sl_done) begin
				shreg_r <= shreg_r;
			end
		end else if (sl_edge) begin
			shreg_r <= cfg_i.low_bit_first ? {in_bit_r, shreg_r[7:1]}
			                               : {shreg_r[6:0], in_bit_r};
		end
	end

	// Last bit joins the byte as it leaves; in the master, leading-edge sampling already shifted it in
	assign rx_push_data = (master_r && !cfg_i.cpha) ? shreg_r :
	                      (cfg_i.low_bit_first ? {in_bit_r, shreg_r[7:1]}
	                                           : {shreg_r[6:0], in_bit_r});
	assign rx_push      = mst_done || sl_done_q;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sl_done_q <= 1'h0;
		end else begin
			sl_done_q <= sl_done;
		end
	end

	// ============================================================
	// Data register holding stage
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			hold_full_r <= 1'h0;
			hold_r      <= '0;
		end else if (tx_valid_i && !hold_full_r) begin
			hold_full_r <= 1'h1;
			hold_r      <= tx_data_i;
		end else if (start || (!master_r && ss_n_i)) begin
			hold_full_r <= 1'h0;
		end
	end

	// Receive buffer; a full buffer stalls the master in done
	spi_buf2 u_rx_buf (
		.clk_i       (sys_clk_i),
		.rst_i       (sys_rst_i),
		.in_data_i   (rx_push_data),
		.in_valid_i  (rx_push),
		.in_ready_o  (rx_room),
		.out_data_o  (rx_data_o),
		.out_valid_o (rx_valid_o),
		.out_ready_i (rx_ready_i)
	);

	// ============================================================
	// Registered pin drive and status outputs
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sck_o             <= 1'h0;
			sck_oe_o          <= 1'h0;
			mosi_o            <= 1'h0;
			mosi_oe_o         <= 1'h0;
			miso_o            <= 1'h0;
			miso_oe_o         <= 1'h0;
			ss_n_o            <= 1'h1;
			ss_oe_o           <= 1'h0;
			master_select_o   <= 1'h0;
			mode_fault_flag_o <= 1'h0;
			irq_o             <= 1'h0;
			busy_o            <= 1'h0;
			tx_ready_o        <= 1'h0;
		end else begin
			sck_o     <= sck_r;
			sck_oe_o  <= enable_i && master_r && !fault;
			mosi_o    <= out_bit;
			miso_o    <= out_bit;
			// Single-wire mode uses mosi in master, miso in slave
			mosi_oe_o <= enable_i && master_r && !fault &&
			             (!cfg_i.serial_pin_control || cfg_i.bidir_output_enable);
			miso_oe_o <= sl_active && !flag_r &&
			             (!cfg_i.serial_pin_control || cfg_i.bidir_output_enable);
			ss_oe_o   <= enable_i && master_r && !fault &&
			             cfg_i.fault_detect_enable && cfg_i.select_output_enable;
			ss_n_o    <= (state_r == ST_IDLE) || abort;
			master_select_o   <= master_r;
			mode_fault_flag_o <= flag_r || fault;
			irq_o             <= (flag_r || fault) && serial_irq_enable_i;
			busy_o            <= state_r != ST_IDLE && !abort;
			tx_ready_o        <= !hold_full_r && !(tx_valid_i);
		end
	end

endmodule

`default_nettype wire

// ---- spi_mm_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module spi_mm_monitor
	import spi_mm_pkg::*;
(
	input wire logic     sys_clk_i,           // clock
	input wire logic     sys_rst_i,           // reset
	input wire logic     enable_i,            // enable
	input wire spi_cfg_t cfg_i,               // config
	input wire logic     master_select_o,     // master
	input wire logic     stop_in_wait_i,      // halt in wait
	input wire logic     wait_mode_i,         // wait
	input wire logic     stop_mode_i,         // stop
	input wire logic     serial_irq_enable_i, // irq enable
	input wire logic     mode_fault_flag_o,   // fault flag
	input wire logic     irq_o,               // irq
	input wire logic     busy_o,              // busy
	input wire logic     tx_valid_i,          // write strobe
	input wire logic     tx_ready_o,          // holding empty
	input wire logic     sck_o,               // sck drive
	input wire logic     sck_oe_o,            // sck enable
	input wire logic     mosi_oe_o,           // mosi enable
	input wire logic     ss_n_i,              // select pin
	input wire logic     ss_n_o,              // select drive
	input wire logic     ss_oe_o              // select enable
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	// ============================================================
	// Helpers
	spi_cfg_t    cfg_q;
	spi_cfg_t    cfg_qq;
	logic [10:0] gap_r;
	logic [10:0] half;
	logic        seen_r;
	logic        halt;
	logic        calm;
	logic        cfg_hit;
	// Bidir only counts while pin control set
	assign halt = stop_mode_i | (wait_mode_i & stop_in_wait_i);
	assign calm = (cfg_i == cfg_q) && (cfg_q == cfg_qq);
	assign half = 11'({8'h00, cfg_i.rate_preselect_bits} + 11'h001) << cfg_i.rate_select_bits;
	assign cfg_hit = ((cfg_i ^ cfg_q) & ~(cfg_q.serial_pin_control ? 13'h0000 : 13'h0040)) != 13'h0000;
	// Config history for change detection
	always_ff @(posedge sys_clk_i) begin
		cfg_q  <= cfg_i;
		cfg_qq <= cfg_q;
	end
	// Gap between sck edges; first edge after any upset not judged
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || ss_n_o || halt || !calm || !master_select_o) begin
			seen_r <= 1'b0;
			gap_r  <= 11'h000;
		end else if ($changed(sck_o)) begin
			seen_r <= 1'b1;
			gap_r  <= 11'h001;
		end else begin
			gap_r <= gap_r + 11'h001;
		end
	end

	// ============================================================
	// Properties
	sequence s_fault_cause;
		enable_i && master_select_o && cfg_i.fault_detect_enable && !cfg_i.select_output_enable && !ss_n_i;
	endsequence
	sequence s_fault_done;
		!master_select_o ##[0:1] (mode_fault_flag_o && !sck_oe_o && !mosi_oe_o && !busy_o);
	endsequence
	property p_reset_idle;
		$past(sys_rst_i) |-> !master_select_o && !mode_fault_flag_o && !irq_o && !busy_o && ss_n_o && !sck_oe_o && !mosi_oe_o && !ss_oe_o;
	endproperty
	property p_rate;
		seen_r && master_select_o && sck_oe_o && $changed(sck_o) |-> gap_r == half;
	endproperty
	property p_ss_low;
		$rose(busy_o) && ss_oe_o |-> ##[0:1] !ss_n_o;
	endproperty
	property p_ss_idle;
		ss_oe_o && !busy_o && !$past(busy_o) |-> ss_n_o;
	endproperty
	property p_sck_idle;
		calm && sck_oe_o && ss_oe_o && ss_n_o && $past(ss_n_o) |-> sck_o == cfg_i.cpol;
	endproperty
	property p_start;
		tx_valid_i && tx_ready_o && master_select_o && !busy_o && enable_i && !halt |-> ##3 busy_o;
	endproperty
	property p_fault;
		s_fault_cause |-> ##2 s_fault_done;
	endproperty
	property p_irq_on;
		(mode_fault_flag_o && serial_irq_enable_i) [*2] |-> irq_o;
	endproperty
	property p_irq_off;
		(!mode_fault_flag_o) [*2] or (!serial_irq_enable_i) [*2] |-> !irq_o;
	endproperty
	property p_pins;
		!master_select_o && !$past(master_select_o) |-> !sck_oe_o && !mosi_oe_o;
	endproperty
	property p_halt;
		(halt && master_select_o) [*3] |-> $stable(sck_o);
	endproperty
	property p_abort;
		busy_o && master_select_o && enable_i && cfg_hit |-> ##[1:2] (!busy_o && ss_n_o);
	endproperty

	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
	a_rate: assert property (p_rate) else $error("sck half period wrong");
	a_ss_low: assert property (p_ss_low) else $error("select not low in transfer");
	a_ss_idle: assert property (p_ss_idle) else $error("select not high when idle");
	a_sck_idle: assert property (p_sck_idle) else $error("sck idle level wrong");
	a_start: assert property (p_start) else $error("write did not start transfer");
	a_fault: assert property (p_fault) else $error("mode fault not handled");
	a_irq_on: assert property (p_irq_on) else $error("irq missing");
	a_irq_off: assert property (p_irq_off) else $error("irq without cause");
	a_pins: assert property (p_pins) else $error("slave drives sck or mosi");
	a_halt: assert property (p_halt) else $error("sck moved while halted");
	a_abort: assert property (p_abort) else $error("config change did not abort");
endmodule

bind spi_master_mode_control spi_mm_monitor u_spi_mm_monitor (.sys_clk_i, .sys_rst_i, .enable_i,
	.cfg_i, .master_select_o, .stop_in_wait_i, .wait_mode_i, .stop_mode_i, .serial_irq_enable_i,
	.mode_fault_flag_o, .irq_o, .busy_o, .tx_valid_i, .tx_ready_o, .sck_o, .sck_oe_o,
	.mosi_oe_o, .ss_n_i, .ss_n_o, .ss_oe_o);

`default_nettype wire

// ---- spi_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module spi_slave_model (
	input  wire logic   sck_i,    // serial clock
	input  wire logic   ss_n_i,   // select, low
	input  wire logic   mosi_i,   // data in
	input  wire logic   cpha_i,   // clock phase
	input  wire logic   lsb_i,    // low bit first
	output var logic       miso_o,   // data out
	output var logic [7:0] rx_o,     // last byte taken
	output var logic [4:0] edges_o,  // sck edges in frame
	output var logic [7:0] frames_o  // frames seen
);
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic       in_frame_r;
	initial begin
		in_frame_r = 1'b0;
		miso_o   = 1'b0;
		frames_o = 8'h00;
		edges_o  = 5'h00;
	end
	// Frame start; reply changes every frame so stale words show
	always @(negedge ss_n_i) begin
		in_frame_r = 1'b1;
		edges_o = 5'h00;
		tx_r    = 8'hA5 ^ frames_o;
		miso_o  = tx_r[lsb_i ? 3'h0 : 3'h7];
	end
	// Sample on one edge, shift on the other
	always @(sck_i) begin
		if (!ss_n_i) begin
			edges_o = edges_o + 5'h01;
			if (edges_o[0] != cpha_i) begin
				sh_r = lsb_i ? {mosi_i, sh_r[7:1]} : {sh_r[6:0], mosi_i};
			end else begin
				miso_o = tx_r[lsb_i ? edges_o[3:1] : 3'h7 - edges_o[3:1]];
			end
		end
	end
	// Select high returns the slave to idle; the unknown-to-high rise at reset is no frame
	always @(posedge ss_n_i) begin
		if (in_frame_r) begin
			rx_o     = sh_r;
			frames_o = frames_o + 8'h01;
			miso_o   = ~miso_o;
		end
		in_frame_r = 1'b0;
	end
endmodule

`default_nettype wire

// ---- spi_master_mode_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
	$display("unexpected %s exp %h got %h", nm, exp, got); end end

module spi_master_mode_control_bench;
	import spi_mm_pkg::*;
	logic      sys_clk_i, sys_rst_i, enable_i, master_select_wr_i, master_select_val_i;
	logic      stop_in_wait_i, wait_mode_i, stop_mode_i, serial_irq_enable_i, fault_clear_i;
	logic      tx_valid_i, rx_ready_i, ss_drv;
	spi_cfg_t  cfg_i, c;
	spi_byte_t tx_data_i, b;
	wire logic master_select_o, mode_fault_flag_o, irq_o, busy_o, tx_ready_o, rx_valid_o;
	wire logic sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, ss_n_o, ss_oe_o, miso_m;
	spi_byte_t rx_data_o;
	wire logic [7:0] s_rx, s_frames;
	wire logic [4:0] s_edges;
	int        err_total, check_count, cyc;
	logic [7:0] nf;
	logic [12:0] msk [9] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100, 13'h0080,
		13'h0008, 13'h0001, 13'h0040};
	// Pin levels from every party's enable; released sck and mosi read inverted
	wire logic sck_w  = sck_oe_o ? sck_o : ~sck_o;
	wire logic mosi_w = mosi_oe_o ? mosi_o : ~mosi_o;
	wire logic miso_w = miso_oe_o ? miso_o : miso_m;
	wire logic ss_w   = ss_oe_o ? ss_n_o : ss_drv;

	spi_master_mode_control u_spi_master_mode_control (.sys_clk_i, .sys_rst_i, .enable_i,
		.cfg_i, .master_select_wr_i, .master_select_val_i, .master_select_o, .stop_in_wait_i,
		.wait_mode_i, .stop_mode_i, .serial_irq_enable_i, .fault_clear_i, .mode_fault_flag_o,
		.irq_o, .busy_o, .tx_data_i, .tx_valid_i, .tx_ready_o, .rx_data_o, .rx_valid_o,
		.rx_ready_i, .sck_i(sck_w), .sck_o, .sck_oe_o, .mosi_i(mosi_w), .mosi_o, .mosi_oe_o,
		.miso_i(miso_w), .miso_o, .miso_oe_o, .ss_n_i(ss_w), .ss_n_o, .ss_oe_o);
	spi_slave_model u_spi_slave_model (.sck_i(sck_w), .ss_n_i(ss_w), .mosi_i(mosi_w),
		.cpha_i(cfg_i.cpha), .lsb_i(cfg_i.low_bit_first), .miso_o(miso_m), .rx_o(s_rx),
		.edges_o(s_edges), .frames_o(s_frames));

	// ============================================================
	// Clock and hang guard
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end

	// ============================================================
	// Tasks; outputs read at the edge see last cycle's settled values
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic arm();
		master_select_wr_i  <= 1'b1;
		master_select_val_i <= 1'b1;
		fault_clear_i       <= 1'b1;
		tick(1);
		master_select_wr_i <= 1'b0;
		fault_clear_i      <= 1'b0;
		tick(3);
	endtask
	task automatic put(input spi_byte_t d);
		for (int i = 0; i < 2000 && tx_ready_o !== 1'b1; i++) tick(1);
		tx_data_i  <= d;
		tx_valid_i <= 1'b1;
		tick(1);
		tx_valid_i <= 1'b0;
		tick(1);
	endtask
	task automatic idle_wait();
		tick(3);
		for (int i = 0; i < 2000 && busy_o !== 1'b0; i++) tick(1);
	endtask
	task automatic get(input spi_byte_t e);
		for (int i = 0; i < 2000 && rx_valid_o !== 1'b1; i++) tick(1);
		`CHK("rx_data", e, rx_data_o)
		rx_ready_i <= 1'b1;
		tick(1);
		rx_ready_i <= 1'b0;
		tick(1);
		nf++;
	endtask
	task automatic results();
		if (err_total == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ============================================================
	// Main sequence
	initial begin
		{sys_rst_i, ss_drv} = 2'b11;
		{enable_i, master_select_wr_i, master_select_val_i, stop_in_wait_i} = 4'h0;
		{wait_mode_i, stop_mode_i, serial_irq_enable_i, fault_clear_i} = 4'h0;
		{tx_valid_i, rx_ready_i, tx_data_i, nf} = 18'h00000;
		cfg_i = spi_cfg_t'(13'h0508); // select out, fault detect, preselect 1
		{err_total, check_count, cyc} = 0;
		tick(10);
		sys_rst_i <= 1'b0;
		tick(2);
		`CHK("idle", 5'h01, {master_select_o, mode_fault_flag_o, sck_oe_o, mosi_oe_o, ss_n_o})
		enable_i <= 1'b1;
		arm();
		// All clock formats, both bit orders, several rates
		for (int i = 0; i < 8; i++) begin
			c = spi_cfg_t'(13'h0500);
			{c.cpol, c.cpha, c.low_bit_first} = {i[0], i[1], i[2]};
			// One-cycle half period is too fast for the registered pin round trip
			{c.rate_preselect_bits, c.rate_select_bits} = {3'(i % 3 + 1), 3'(i / 5)};
			cfg_i <= c;
			tick(4);
			b = 8'h96 ^ 8'(i * 37);
			put(b);
			idle_wait();
			`CHK("slave_rx", b, s_rx)
			`CHK("edges", 5'h10, s_edges)
			get(8'hA5 ^ nf);
		end
		// Back to back with receiver stalled: third word waits in done
		cfg_i <= spi_cfg_t'(13'h0508);
		tick(4);
		for (int i = 0; i < 3; i++) put(8'h11 * 8'(i + 1));
		tick(300);
		`CHK("stall", 2'b11, {busy_o, rx_valid_o})
		for (int i = 0; i < 3; i++) get(8'hA5 ^ nf);
		idle_wait();
		`CHK("last_rx", 8'h33, s_rx)
		// Halt by stop, then by wait with stop_in_wait, then plain wait
		put(8'hC3);
		tick(10);
		stop_mode_i <= 1'b1;
		tick(30);
		`CHK("paused", 1'b1, busy_o)
		{stop_mode_i, wait_mode_i, stop_in_wait_i} <= 3'b011;
		tick(30);
		`CHK("paused", 1'b1, busy_o)
		stop_in_wait_i <= 1'b0;
		idle_wait();
		`CHK("resumed", 8'hC3, s_rx)
		get(8'hA5 ^ nf);
		wait_mode_i <= 1'b0;
		// Each listed config change aborts; select released to the slave
		for (int j = 0; j < 9; j++) begin
			c = spi_cfg_t'((j == 8) ? 13'h0588 : 13'h0508);
			cfg_i <= c;
			arm();
			put(8'h5A);
			tick(8);
			`CHK("running", 1'b1, busy_o)
			cfg_i <= c ^ spi_cfg_t'(msk[j]);
			tick(4);
			`CHK("aborted", 2'b01, {busy_o, ss_n_o})
			nf++;
			`CHK("slave_idle", nf, s_frames)
		end
		// Mode fault from a competing master, irq raised, masked, cleared
		cfg_i <= spi_cfg_t'(13'h0108);
		serial_irq_enable_i <= 1'b1;
		arm();
		put(8'h77);
		tick(8);
		ss_drv <= 1'b0;
		tick(3);
		`CHK("fault", 6'h18, {master_select_o, mode_fault_flag_o, irq_o, busy_o, sck_oe_o, mosi_oe_o})
		ss_drv <= 1'b1;
		tick(3);
		`CHK("miso_oe", 1'b0, miso_oe_o)
		serial_irq_enable_i <= 1'b0;
		tick(3);
		`CHK("masked", 2'b10, {mode_fault_flag_o, irq_o})
		fault_clear_i <= 1'b1;
		tick(1);
		fault_clear_i <= 1'b0;
		tick(3);
		`CHK("cleared", 2'b00, {mode_fault_flag_o, irq_o})
		results();
	end
endmodule

`default_nettype wire
